/* File: bcd_map.svh */
// constants for the branch-cycle and opcode decoder
// included by the core and the opcode table; definitions only
`ifndef BCD_MAP_SVH
`define BCD_MAP_SVH

`define BCD_DUMMY_ADDR 16'hFFFF
`define BCD_PC_RESET 16'hF800
`define BCD_SP_RESET 16'h00FF
`define BCD_WAIT_PUSH_LAST 3'h6
`define BCD_CALL_PUSH_LAST 3'h1
`define BCD_OP_BRA 8'h20
`define BCD_OP_BRN 8'h21
`define BCD_OP_WAIT 8'h3E
`define BCD_OP_CALL_REL 8'h8D
`define BCD_OP_TEST_A 8'h4E
`define BCD_OP_TEST_B 8'h5E
`define BCD_COL_RELATIVE 4'h2
`define BCD_ROM2K_BASE 16'hF800
`define BCD_ROM4K_BASE 16'hF000
`define BCD_HOLE_BASE 16'hE000

`endif

/* File: bcd_pkg.sv */
// types used by the decoder core for its states and map modes
// no assumptions beyond a SystemVerilog compiler
package bcd_pkg;

    typedef enum logic [7:0] {
        BCD_S_FETCH = 8'b0000_0001,
        BCD_S_OPND = 8'b0000_0010,
        BCD_S_DUMMY = 8'b0000_0100,
        BCD_S_SUBFETCH = 8'b0000_1000,
        BCD_S_PUSH = 8'b0001_0000,
        BCD_S_WAITHOLD = 8'b0010_0000,
        BCD_S_TEST = 8'b0100_0000,
        BCD_S_EXEC = 8'b1000_0000
    } bcd_state_type;

    typedef enum logic [1:0] {
        BCD_MAP_NATIVE = 2'h0,
        BCD_MAP_ROM2K = 2'h1,
        BCD_MAP_ROM4K = 2'h2
    } bcd_compat_type;

endpackage

/* File: bcd_opcode_table.sv */
// opcode table: byte length, cycle count and class of each opcode
// purely combinational; the core registers what it needs
`timescale 1ns/1ps
`default_nettype none
`include "bcd_map.svh"

module bcd_opcode_table (
    // opcode in
    input wire logic [7:0] opcode,
    // decoded attributes
    output logic [1:0] op_length,
    output logic [3:0] op_cycles,
    output logic op_undefined,
    output logic op_test
);

    function automatic logic [3:0] col_base(input logic [3:0] hi);
        unique case (hi)
            4'h2, 4'h3, 4'h9, 4'hD: col_base = 4'h3;
            4'h6, 4'h7: col_base = 4'h6;
            4'hA, 4'hB, 4'hE, 4'hF: col_base = 4'h4;
            default: col_base = 4'h2;
        endcase
    endfunction

    function automatic logic [1:0] col_len(input logic [3:0] hi);
        unique case (hi)
            4'h2, 4'h6, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE: col_len = 2'h2;
            4'h7, 4'hB, 4'hF: col_len = 2'h3;
            default: col_len = 2'h1;
        endcase
    endfunction

    // extra cycles added to the column base; jump is three fewer
    function automatic logic [3:0] row_extra(input logic [7:0] op);
        logic [3:0] hi;
        logic [3:0] lo;
        hi = op[7:4];
        lo = op[3:0];
        row_extra = 4'h0;
        if (hi == 4'h0 && (lo == 4'h4 || lo == 4'h5 || lo == 4'h8 || lo == 4'h9)) begin
            row_extra = 4'h1;
        end else if (hi == 4'h3) begin
            unique case (lo)
                4'h2, 4'h3, 4'hC: row_extra = 4'h1;
                4'h8, 4'h9: row_extra = 4'h2;
                4'hB, 4'hD: row_extra = 4'h7;
                4'hE: row_extra = 4'h6;
                4'hF: row_extra = 4'h9;
                default: row_extra = 4'h0;
            endcase
        end else if (hi >= 4'h8) begin
            unique case (lo)
                4'h3: row_extra = 4'h2;
                4'hC: row_extra = (hi < 4'hC) ? 4'h2 : 4'h1;
                4'hD: row_extra = (hi == 4'h8) ? 4'h4 : ((hi < 4'hC) ? 4'h2 : 4'h1);
                4'hE, 4'hF: row_extra = 4'h1;
                default: row_extra = 4'h0;
            endcase
        end
    endfunction

    function automatic logic is_undef(input logic [7:0] op);
        unique case (op)
            8'h00, 8'h02, 8'h03, 8'h12, 8'h13, 8'h14, 8'h15, 8'h18, 8'h1A,
            8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h41, 8'h42, 8'h45, 8'h4B, 8'h4E,
            8'h51, 8'h52, 8'h55, 8'h5B, 8'h5E, 8'h61, 8'h62, 8'h65, 8'h6B,
            8'h71, 8'h72, 8'h75, 8'h7B, 8'h87, 8'h8F, 8'hC7, 8'hCD, 8'hCF:
                is_undef = 1'b1;
            default: is_undef = 1'b0;
        endcase
    endfunction

    function automatic logic is_three_byte_imm(input logic [7:0] op);
        unique case (op)
            8'h83, 8'h8C, 8'h8E, 8'hC3, 8'hCC, 8'hCE, 8'h8F, 8'hCD, 8'hCF:
                is_three_byte_imm = 1'b1;
            default: is_three_byte_imm = 1'b0;
        endcase
    endfunction

    always_comb begin
        op_test = (opcode == `BCD_OP_TEST_A) || (opcode == `BCD_OP_TEST_B);
        op_undefined = is_undef(opcode);
        op_length = is_three_byte_imm(opcode) ? 2'h3 : col_len(opcode[7:4]);
        if (opcode[7:4] >= 4'h6 && opcode[7:4] <= 4'h7 && opcode[3:0] == 4'hE) begin
            op_cycles = col_base(opcode[7:4]) - 4'h3;
        end else begin
            op_cycles = col_base(opcode[7:4]) + row_extra(opcode);
        end
    end

endmodule
`default_nettype wire

/* File: bcd_core.sv */
// instruction sequencer: drives the system bus for branches, the
// relative call, the wait state, test opcodes and generic opcodes
// assumes single-cycle synchronous memory answering on data_in
`timescale 1ns/1ps
`default_nettype none
`include "bcd_map.svh"

// Operation
// - in the wait state the bus repeats reads of the entry stack pointer minus seven.
// - the wait instruction never floats any port; port drive stays as configured.
// - every relative branch is three read cycles: opcode, offset, dummy read of FFFF.
// - the relative call is six cycles, writing return low at SP and return high at SP-1.
// - cycle four of the relative call reads the subroutine start address.
// - thirty-six opcodes are flagged undefined and have no defined result.
// - opcodes 4E and 5E step the program counter every cycle until reset.
// - immediate 16-bit load, add, subtract, compare and 8F, CD, CF are three bytes long.
// - cycle count is the column base plus the extra cycles of the opcode; jumps 6E and 7E take the base minus three.
// - stack pushes post-decrement: return low, high, index low, high, A, B, codes.
module bcd_core #(
    parameter logic [15:0] PC_RESET = `BCD_PC_RESET,
    parameter logic [15:0] SP_RESET = `BCD_SP_RESET
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // system bus
    output logic [15:0] addr_out,
    output logic rw_out,
    output logic [7:0] data_out,
    input wire logic [7:0] data_in,
    // flag logic and register file
    input wire logic branch_cond,
    input wire logic wake_req,
    input wire logic [7:0] acc_a,
    input wire logic [7:0] acc_b,
    input wire logic [15:0] index_reg,
    input wire logic [7:0] cond_codes,
    // memory map
    input wire logic [1:0] compat_mode,
    output logic rom_select,
    output logic addr_unusable,
    // port drive
    input wire logic [7:0] port_dir,
    output logic [7:0] port_oe_n,
    // status
    output logic undefined_op,
    output logic waiting
);

    bcd_pkg::bcd_state_type state_q;
    logic [15:0] pc_q;
    logic [15:0] sp_q;
    logic [15:0] ret_q;
    logic [15:0] target_q;
    logic [7:0] op_q;
    logic [7:0] off_q;
    logic [3:0] cnt_q;
    logic [2:0] push_idx_q;
    logic [1:0] len_q;
    logic [3:0] cyc_q;
    logic [1:0] tab_len;
    logic [3:0] tab_cyc;
    logic tab_undef;
    logic tab_test;
    logic [15:0] branch_dest;
    logic branch_taken;
    logic [2:0] push_last;

    bcd_opcode_table u_table (
        .opcode(data_in),
        .op_length(tab_len),
        .op_cycles(tab_cyc),
        .op_undefined(tab_undef),
        .op_test(tab_test)
    );

    function automatic logic [7:0] push_byte(input logic [2:0] idx, input logic [15:0] ret,
                                             input logic [15:0] x, input logic [7:0] a,
                                             input logic [7:0] b, input logic [7:0] cc);
        unique case (idx)
            3'h0: push_byte = ret[7:0];
            3'h1: push_byte = ret[15:8];
            3'h2: push_byte = x[7:0];
            3'h3: push_byte = x[15:8];
            3'h4: push_byte = a;
            3'h5: push_byte = b;
            default: push_byte = cc;
        endcase
    endfunction

    assign branch_dest = pc_q + {{8{off_q[7]}}, off_q};
    assign branch_taken = (op_q == `BCD_OP_BRA) ||
                          ((op_q != `BCD_OP_BRN) && branch_cond);
    assign push_last = (op_q == `BCD_OP_WAIT) ? `BCD_WAIT_PUSH_LAST : `BCD_CALL_PUSH_LAST;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= bcd_pkg::BCD_S_FETCH;
            pc_q <= PC_RESET;
            sp_q <= SP_RESET;
            ret_q <= 16'h0000;
            target_q <= 16'h0000;
            op_q <= 8'h00;
            off_q <= 8'h00;
            cnt_q <= 4'h0;
            push_idx_q <= 3'h0;
            len_q <= 2'h1;
            cyc_q <= 4'h2;
            undefined_op <= 1'b0;
            addr_out <= PC_RESET;
            rw_out <= 1'b1;
            data_out <= 8'h00;
        end else begin
            unique case (state_q)
                bcd_pkg::BCD_S_FETCH: begin
                    op_q <= data_in;
                    len_q <= tab_len;
                    cyc_q <= tab_cyc;
                    undefined_op <= tab_undef;
                    pc_q <= pc_q + 16'h0001;
                    addr_out <= pc_q + 16'h0001;
                    cnt_q <= 4'h2;
                    if (tab_test) begin
                        state_q <= bcd_pkg::BCD_S_TEST;
                    end else if (data_in[7:4] == `BCD_COL_RELATIVE ||
                                 data_in == `BCD_OP_CALL_REL || data_in == `BCD_OP_WAIT) begin
                        state_q <= bcd_pkg::BCD_S_OPND;
                    end else begin
                        state_q <= bcd_pkg::BCD_S_EXEC;
                    end
                end
                bcd_pkg::BCD_S_OPND: begin
                    if (op_q == `BCD_OP_WAIT) begin
                        // next opcode is read but not consumed; return is its address
                        ret_q <= pc_q;
                        push_idx_q <= 3'h0;
                        addr_out <= sp_q;
                        rw_out <= 1'b0;
                        data_out <= pc_q[7:0];
                        state_q <= bcd_pkg::BCD_S_PUSH;
                    end else begin
                        off_q <= data_in;
                        pc_q <= pc_q + 16'h0001;
                        addr_out <= `BCD_DUMMY_ADDR;
                        state_q <= bcd_pkg::BCD_S_DUMMY;
                    end
                end
                bcd_pkg::BCD_S_DUMMY: begin
                    if (op_q == `BCD_OP_CALL_REL) begin
                        target_q <= branch_dest;
                        addr_out <= branch_dest;
                        rw_out <= 1'b1;
                        state_q <= bcd_pkg::BCD_S_SUBFETCH;
                    end else begin
                        if (branch_taken) begin
                            pc_q <= branch_dest;
                        end
                        addr_out <= branch_taken ? branch_dest : pc_q;
                        state_q <= bcd_pkg::BCD_S_FETCH;
                    end
                end
                bcd_pkg::BCD_S_SUBFETCH: begin
                    // opcode here is refetched after the pushes, so it is not kept
                    ret_q <= pc_q;
                    pc_q <= target_q;
                    push_idx_q <= 3'h0;
                    addr_out <= sp_q;
                    rw_out <= 1'b0;
                    data_out <= pc_q[7:0];
                    state_q <= bcd_pkg::BCD_S_PUSH;
                end
                bcd_pkg::BCD_S_PUSH: begin
                    sp_q <= sp_q - 16'h0001;
                    if (push_idx_q == push_last) begin
                        rw_out <= 1'b1;
                        if (op_q == `BCD_OP_WAIT) begin
                            addr_out <= sp_q - 16'h0001;
                            state_q <= bcd_pkg::BCD_S_WAITHOLD;
                        end else begin
                            addr_out <= pc_q;
                            state_q <= bcd_pkg::BCD_S_FETCH;
                        end
                    end else begin
                        push_idx_q <= push_idx_q + 3'h1;
                        addr_out <= sp_q - 16'h0001;
                        data_out <= push_byte(push_idx_q + 3'h1, ret_q, index_reg,
                                              acc_a, acc_b, cond_codes);
                    end
                end
                bcd_pkg::BCD_S_WAITHOLD: begin
                    // address holds at entry SP minus seven until woken
                    if (wake_req) begin
                        addr_out <= pc_q;
                        state_q <= bcd_pkg::BCD_S_FETCH;
                    end
                end
                bcd_pkg::BCD_S_TEST: begin
                    pc_q <= pc_q + 16'h0001;
                    addr_out <= pc_q + 16'h0001;
                end
                bcd_pkg::BCD_S_EXEC: begin
                    // operand bytes are read in order, remaining cycles are dummy reads
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q <= {2'b00, len_q}) begin
                        pc_q <= pc_q + 16'h0001;
                    end
                    if (cnt_q >= cyc_q) begin
                        addr_out <= (cnt_q <= {2'b00, len_q}) ? pc_q + 16'h0001 : pc_q;
                        state_q <= bcd_pkg::BCD_S_FETCH;
                    end else if (cnt_q + 4'h1 <= {2'b00, len_q}) begin
                        addr_out <= pc_q + 16'h0001;
                    end else begin
                        addr_out <= `BCD_DUMMY_ADDR;
                    end
                end
                default: begin
                    addr_out <= pc_q;
                    rw_out <= 1'b1;
                    state_q <= bcd_pkg::BCD_S_FETCH;
                end
            endcase
        end
    end

    // port drive follows direction config only; waiting never floats it
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            port_oe_n <= 8'hFF;
        end else begin
            port_oe_n <= ~port_dir;
        end
    end

    assign waiting = (state_q == bcd_pkg::BCD_S_WAITHOLD);

    always_comb begin
        rom_select = 1'b0;
        addr_unusable = 1'b0;
        unique case (compat_mode)
            bcd_pkg::BCD_MAP_ROM2K: begin
                rom_select = (addr_out >= `BCD_ROM2K_BASE);
                addr_unusable = (addr_out >= `BCD_HOLE_BASE) &&
                                (addr_out < `BCD_ROM2K_BASE);
            end
            bcd_pkg::BCD_MAP_ROM4K: begin
                rom_select = (addr_out >= `BCD_ROM4K_BASE);
                addr_unusable = (addr_out >= `BCD_HOLE_BASE) &&
                                (addr_out < `BCD_ROM4K_BASE);
            end
            default: begin
                rom_select = 1'b0;
                addr_unusable = 1'b0;
            end
        endcase
    end

endmodule
`default_nettype wire

/* File: bcd_core_sva.sv */
// concurrent checks on the ports of the decoder core
// sees only top-level ports; attached by the bind at the foot
`timescale 1ns/1ps
`default_nettype none

module bcd_core_sva (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // system bus
    input wire logic [15:0] addr_out,
    input wire logic rw_out,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_in,
    // wait, map and port drive
    input wire logic wake_req,
    input wire logic [1:0] compat_mode,
    input wire logic rom_select,
    input wire logic addr_unusable,
    input wire logic [7:0] port_dir,
    input wire logic [7:0] port_oe_n,
    input wire logic waiting
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_port_drive: assert property (
        $past(reset_n) |-> port_oe_n == ~$past(port_dir))
        else $error("port drive does not follow direction");
    a_rom_small: assert property (
        compat_mode == 2'h1 |-> rom_select == (addr_out >= 16'hf800)
        && addr_unusable == (addr_out >= 16'he000 && addr_out < 16'hf800))
        else $error("small rom map wrong");
    a_rom_large: assert property (
        compat_mode == 2'h2 |-> rom_select == (addr_out >= 16'hf000)
        && addr_unusable == (addr_out >= 16'he000 && addr_out < 16'hf000))
        else $error("large rom map wrong");
    a_wait_hold: assert property (
        waiting && $past(waiting) |-> rw_out && $stable(addr_out))
        else $error("wait hold does not repeat one read");
    a_wait_exit: assert property (
        waiting && wake_req |=> !waiting)
        else $error("wait not left on wake");
    a_push_order: assert property (
        !rw_out && !$past(rw_out) |-> addr_out == $past(addr_out) - 16'h0001)
        else $error("stack writes not post-decrement");
    a_dummy_read: assert property (
        addr_out == 16'hffff |-> rw_out)
        else $error("dummy cycle is not a read");
    a_call_target: assert property (
        $fell(rw_out) && $past(addr_out, 2) == 16'hffff |-> $past(addr_out) ==
        $past(addr_out, 3) + 16'h0001 + 16'($signed($past(data_in, 3))))
        else $error("call target read at wrong address");
    a_call_push: assert property (
        $fell(rw_out) && $past(addr_out, 2) == 16'hffff
        |-> data_out == 8'($past(addr_out, 3) + 16'h0001) ##1 !rw_out
        && data_out == 8'(($past(addr_out, 4) + 16'h0001) >> 8))
        else $error("return address push wrong");

    c_wait_wake: cover property (waiting && wake_req);
    c_call: cover property ($fell(rw_out) && $past(addr_out, 2) == 16'hffff);
    c_rom_large: cover property (compat_mode == 2'h2 && rom_select);
endmodule

bind bcd_core bcd_core_sva chk_u (.ref_clk(ref_clk), .reset_n(reset_n),
    .addr_out(addr_out), .rw_out(rw_out), .data_out(data_out), .data_in(data_in),
    .wake_req(wake_req), .compat_mode(compat_mode), .rom_select(rom_select),
    .addr_unusable(addr_unusable), .port_dir(port_dir), .port_oe_n(port_oe_n),
    .waiting(waiting));

`default_nettype wire

/* File: bcd_bus_mem.sv */
// zero-wait memory standing on the far side of the system bus
// the bench loads program bytes into mem while the core is in reset
`timescale 1ns/1ps
`default_nettype none

module bcd_bus_mem (
    // clock
    input wire logic ref_clk,
    // system bus from the core
    input wire logic [15:0] addr,
    input wire logic rw,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:65535];

    initial begin
        for (int i = 0; i < 65536; i++)
            mem[i] = 8'h01;
    end

    // not driving during writes: show the inverse so a stale sample is caught
    assign rdata = rw ? mem[addr] : ~wdata;

    always @(posedge ref_clk) begin
        if (!rw)
            mem[addr] <= wdata;
    end
endmodule

`default_nettype wire

/* File: branch_cycle_and_opcode_decoder_test.sv */
// self-checking bench: branch, call, wait and test-opcode bus walks
// assumes bcd_core, bcd_bus_mem and the bound checker are compiled
`timescale 1ns/1ps
`default_nettype none

module branch_cycle_and_opcode_decoder_test;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] addr_out;
    logic rw_out;
    logic [7:0] data_out, data_in;
    logic branch_cond = 1'b0;
    logic wake_req = 1'b0;
    logic [7:0] acc_a = 8'h00, acc_b = 8'h00, cond_codes = 8'h00, port_dir = 8'h00;
    logic [15:0] index_reg = 16'h0000;
    logic [1:0] compat_mode = 2'h0;
    logic rom_select, addr_unusable, undefined_op, waiting;
    logic [7:0] port_oe_n;
    int err_total = 0;
    int n_compared = 0;
    int seed = 32'hf0fe_56e0;
    logic [15:0] p, t, c, r;
    logic [7:0] o1, o2, u;
    logic cond_seen;
    logic [7:0] w [7];

    bcd_core #(.PC_RESET(16'hf7f0), .SP_RESET(16'h00ff)) dut_u (.ref_clk(ref_clk),
        .reset_n(reset_n), .addr_out(addr_out), .rw_out(rw_out), .data_out(data_out),
        .data_in(data_in), .branch_cond(branch_cond), .wake_req(wake_req),
        .acc_a(acc_a), .acc_b(acc_b), .index_reg(index_reg), .cond_codes(cond_codes),
        .compat_mode(compat_mode), .rom_select(rom_select),
        .addr_unusable(addr_unusable), .port_dir(port_dir), .port_oe_n(port_oe_n),
        .undefined_op(undefined_op), .waiting(waiting));
    bcd_bus_mem mem_u (.ref_clk(ref_clk), .addr(addr_out), .rw(rw_out),
        .wdata(data_out), .rdata(data_in));

    always #25 ref_clk = ~ref_clk;

    always @(negedge ref_clk) begin
        port_dir <= 8'($random(seed));
        branch_cond <= 1'($random(seed));
        compat_mode <= 2'($unsigned($random(seed)) % 3);
    end

    // condition as the core sees it at the edge ending the dummy cycle
    always @(posedge ref_clk) begin
        cond_seen <= branch_cond;
    end

    function automatic logic [15:0] rel(logic [15:0] a, logic [7:0] o);
        return a + 16'h0002 + 16'($signed(o));
    endfunction

    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one bus cycle: compare what stands now, then move to the next cycle
    task automatic cyc(logic [15:0] a, logic wr, logic [7:0] d);
        chk("addr", addr_out, a);
        chk("rw", 16'(rw_out), 16'(wr));
        if (!wr)
            chk("data", 16'(data_out), 16'(d));
        @(negedge ref_clk);
    endtask

    task automatic put(logic [15:0] a, logic [7:0] b0, logic [7:0] b1);
        mem_u.mem[a] = b0;
        mem_u.mem[a + 16'h0001] = b1;
    endtask

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        err_total++;
        $display("watchdog expired");
        wrap_up();
    end

    initial begin
        for (int k = 0; k < 6; k++) begin
            reset_n = 1'b0;
            @(negedge ref_clk);
            o1 = 8'($unsigned($random(seed)) % 48 + 16);
            o2 = 8'($unsigned($random(seed)) % 48 + 16);
            // extended jump and the three-byte undefined codes share one walk
            u = (k % 4 == 0) ? 8'h7e : ((k % 4 == 1) ? 8'h8f : ((k % 4 == 2) ? 8'hcd : 8'hcf));
            acc_a = 8'($random(seed));
            acc_b = 8'($random(seed));
            cond_codes = 8'($random(seed));
            index_reg = 16'($random(seed));
            p = 16'hf7f0;
            t = rel(p, o1);
            c = rel(t + 16'h0008, o2);
            r = c + 16'h0001;
            w = '{r[7:0], r[15:8], index_reg[7:0], index_reg[15:8], acc_a, acc_b, cond_codes};
            // conditional branch to t; when not taken an always-branch follows to t
            put(p, 8'h22 + 8'($unsigned($random(seed)) % 14), o1);
            put(p + 16'h0002, 8'h20, o1 - 8'h02);
            put(t, 8'h21, 8'h05);
            put(t + 16'h0002, 8'h8c, 8'h12);
            put(t + 16'h0005, u, 8'h00);
            put(t + 16'h0008, 8'h8d, o2);
            put(c, 8'h3e, (k % 2 == 1) ? 8'h5e : 8'h4e);
            repeat (5) @(negedge ref_clk);
            reset_n = 1'b1;
            cyc(p, 1'b1, 8'h00);
            cyc(p + 16'h0001, 1'b1, 8'h00);
            cyc(16'hffff, 1'b1, 8'h00);
            if (!cond_seen) begin
                cyc(p + 16'h0002, 1'b1, 8'h00);
                cyc(p + 16'h0003, 1'b1, 8'h00);
                cyc(16'hffff, 1'b1, 8'h00);
            end
            cyc(t, 1'b1, 8'h00);
            cyc(t + 16'h0001, 1'b1, 8'h00);
            cyc(16'hffff, 1'b1, 8'h00);
            cyc(t + 16'h0002, 1'b1, 8'h00);
            chk("undef", 16'(undefined_op), 16'h0000);
            cyc(t + 16'h0003, 1'b1, 8'h00);
            cyc(t + 16'h0004, 1'b1, 8'h00);
            cyc(16'hffff, 1'b1, 8'h00);
            cyc(t + 16'h0005, 1'b1, 8'h00);
            chk("undef", 16'(undefined_op), 16'(u != 8'h7e));
            cyc(t + 16'h0006, 1'b1, 8'h00);
            cyc(t + 16'h0007, 1'b1, 8'h00);
            cyc(t + 16'h0008, 1'b1, 8'h00);
            cyc(t + 16'h0009, 1'b1, 8'h00);
            cyc(16'hffff, 1'b1, 8'h00);
            cyc(c, 1'b1, 8'h00);
            cyc(16'h00ff, 1'b0, 8'(t + 16'h000a));
            cyc(16'h00fe, 1'b0, 8'((t + 16'h000a) >> 8));
            cyc(c, 1'b1, 8'h00);
            cyc(r, 1'b1, 8'h00);
            for (int i = 0; i < 7; i++)
                cyc(16'h00fd - 16'(i), 1'b0, w[i]);
            repeat (3) cyc(16'h00f6, 1'b1, 8'h00);
            chk("waiting", 16'(waiting), 16'h0001);
            wake_req = 1'b1;
            cyc(16'h00f6, 1'b1, 8'h00);
            wake_req = 1'b0;
            for (int i = 1; i < 8; i++)
                cyc(c + 16'(i), 1'b1, 8'h00);
            $display("test %0d done", k);
        end
        wrap_up();
    end
endmodule

`default_nettype wire
